// ### shared/sup_pkg.sv
// Constants, register map and state codes of the regulator supervisor.
// Assumes a 20 MHz core clock taken from the switching oscillator domain.
package sup_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_KHZ      = 20000;
  localparam int unsigned CLK_NS       = 50;
  localparam int unsigned FSW_DEF_KHZ  = 500;
  localparam int unsigned FSW_MIN_KHZ  = 200;
  localparam int unsigned FSW_MAX_KHZ  = 2200;
  localparam int unsigned FSW_FOLD_KHZ = 40;
  localparam int unsigned SYNC_DLY_NS  = 220;
  localparam int unsigned BOOST_SS_US  = 500;

  localparam int          PER_W    = 9;
  localparam logic [8:0]  PER_DEF  = 9'(CLK_KHZ / FSW_DEF_KHZ);
  localparam logic [8:0]  PER_MIN  = 9'((CLK_KHZ + FSW_MAX_KHZ - 1)
                                        / FSW_MAX_KHZ);
  localparam logic [8:0]  PER_MAX  = 9'(CLK_KHZ / FSW_MIN_KHZ);
  localparam logic [8:0]  PER_FOLD = 9'(CLK_KHZ / FSW_FOLD_KHZ);
  localparam int unsigned SYNC_DLY_CYC = (SYNC_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BOOST_SS_CYC_DEF = BOOST_SS_US * CLK_KHZ / 1000;
  localparam logic [7:0]  FOLD_FULL = 8'hFF;

  // Counts in switching periods.
  localparam int          CNT_W         = 16;
  localparam int unsigned SS_TICKS_DEF  = 1024;
  localparam int unsigned HICCUP_MULT   = 5;
  localparam logic [7:0]  PG_DLY_TICKS  = 8'h80;
  localparam logic [2:0]  PG_TRIP_TICKS = 3'h2;
  localparam logic [2:0]  OC2_DLY_TICKS = 3'h2;
  localparam logic [2:0]  LISTEN_TICKS  = 3'h4;
  localparam logic [2:0]  LOSS_TICKS    = 3'h3;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  REG_PERIOD = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  localparam int ST_PG     = 0;
  localparam int ST_BOOSTM = 1;
  localparam int ST_BOOSTA = 2;
  localparam int ST_OVL    = 3;
  localparam int ST_OTL    = 4;
  localparam int ST_FOLLOW = 5;
  localparam int ST_FOLD   = 6;
  localparam int ST_LSB    = 8;

  typedef enum logic [3:0] {
    ST_OFF    = 4'h1,
    ST_SOFT   = 4'h2,
    ST_RUN    = 4'h4,
    ST_HICCUP = 4'h8
  } sup_state_e;

endpackage

// ### rtl/input_sync.sv
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherence is implied.
`timescale 1ns/100ps
module input_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk, // Core clock.
  input  wire logic             rst,      // Asynchronous reset.
  input  wire logic [WIDTH-1:0] d,        // Raw levels.
  output      logic [WIDTH-1:0] q         // Synchronised levels.
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s r_q;
  sync_s r_d;

  always_comb begin
    r_d.meta   = d;
    r_d.stable = r_q.meta;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.stable;

endmodule

// ### rtl/switch_clock_gen.sv
// Switching period counter with phase alignment to an external edge.
// Assumes period stays at least PER_MIN; a shorter value wraps early.
`timescale 1ns/100ps
module switch_clock_gen #(
  parameter int PW = 9
) (
  input  wire logic          core_clk,  // Core clock.
  input  wire logic          rst,       // Asynchronous reset.
  input  wire logic [PW-1:0] period,    // Period in core cycles.
  input  wire logic          align,     // External rising edge seen.
  output      logic          tick,      // Switch node rising edge.
  output      logic [PW-1:0] phase,     // Cycles since tick.
  output      logic          local_clk  // Local clock, high first half.
);
  import sup_pkg::*;

  typedef struct packed {
    logic [PW-1:0] cnt;
  } gen_s;

  gen_s g_q;
  gen_s g_d;
  logic [PW-1:0] half;
  logic [PW-1:0] off;

  // Places the next tick half a period plus the fixed delay after align.
  always_comb begin
    half = period >> 1;
    off  = half + PW'(SYNC_DLY_CYC);
    if (off >= period) begin
      off = off - period;
    end
    g_d = g_q;
    if (align) begin
      g_d.cnt = (off == '0) ? '0 : period - off;
    end else if (g_q.cnt >= period - PW'(1)) begin
      g_d.cnt = '0;
    end else begin
      g_d.cnt = g_q.cnt + PW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      g_q <= '0;
    end else begin
      g_q <= g_d;
    end
  end

  assign tick      = (g_q.cnt == '0);
  assign phase     = g_q.cnt;
  assign local_clk = (g_q.cnt < half);

endmodule

// ### rtl/regulator_fault_supervisor.sv
// Supervisory logic of a buck or boost-buck regulator controller.
// Assumes comparator inputs are levels from the analog front end and
// that rst is the bias-supply power-on reset.
`timescale 1ns/100ps
module regulator_fault_supervisor #(
  parameter int SS_TICKS     = sup_pkg::SS_TICKS_DEF,
  parameter int BOOST_SS_CYC = sup_pkg::BOOST_SS_CYC_DEF
) (
  input  wire logic                      core_clk,     // Core clock.
  input  wire logic                      rst,          // Bias POR.
  input  wire logic [sup_pkg::ADDR_W-1:0] awaddr,      // Write address.
  input  wire logic                      awvalid,      // Write addr valid.
  output      logic                      awready,      // Write addr ready.
  input  wire logic [31:0]               wdata,        // Write data.
  input  wire logic [3:0]                wstrb,        // Byte enables.
  input  wire logic                      wvalid,       // Write data valid.
  output      logic                      wready,       // Write data ready.
  output      logic [1:0]                bresp,        // Write response.
  output      logic                      bvalid,       // Response valid.
  input  wire logic                      bready,       // Response ready.
  input  wire logic [sup_pkg::ADDR_W-1:0] araddr,      // Read address.
  input  wire logic                      arvalid,      // Read addr valid.
  output      logic                      arready,      // Read addr ready.
  output      logic [31:0]               rdata,        // Read data.
  output      logic [1:0]                rresp,        // Read response.
  output      logic                      rvalid,       // Read valid.
  input  wire logic                      rready,       // Read ready.
  input  wire logic                      chip_enable_in,   // Enable pin.
  input  wire logic                      bias_1v_ok_in,    // Bias above 1 V.
  input  wire logic                      boost_sense_in,   // Sense >= 0.2 V.
  input  wire logic                      boost_low_in,     // Sense < 0.8 V.
  input  wire logic                      aux_supply_sense, // Aux < 0.8 V.
  input  wire logic                      freq_set_pin,     // Resistor fitted.
  input  wire logic                      pulse_skip_mode,  // Pulse skipping.
  input  wire logic                      fb_uv_in,         // Below 90 %.
  input  wire logic                      fb_ov1_in,        // Above 110 %.
  input  wire logic                      fb_ov2_in,        // Above 120 %.
  input  wire logic                      fb_at_ref_in,     // At or below ref.
  input  wire logic [7:0]                vout_ratio_in,    // Vout / target.
  input  wire logic                      pwm_comp_in,      // On-time end.
  input  wire logic                      primary_peak_limit,   // First limit.
  input  wire logic                      secondary_peak_limit, // Second.
  input  wire logic                      temp_hot_in,      // Junction hot.
  input  wire logic                      temp_cool_in,     // Below lower.
  input  wire logic                      sync_clock_i,     // Sync pin level.
  output      logic                      sync_clock_o,     // Sync drive.
  output      logic                      sync_clock_oe,    // Sync enable.
  output      logic                      high_side_gate,   // High-side on.
  output      logic                      low_side_gate,    // Low-side on.
  output      logic                      power_good_out,   // Good released.
  output      logic                      power_good_oe     // Pulls pin low.
);
  import sup_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    sup_state_e       st;
    logic [8:0]       period;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             aw_have;
    logic             w_have;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             boost_mode;
    logic             boost_on;
    logic [CNT_W-1:0] bss_cnt;
    logic             hs;
    logic             ls;
    logic             ov_lat;
    logic             otp_lat;
    logic             fold;
    logic             pk1_seen;
    logic [CNT_W-1:0] tcnt;
    logic             oc2_pend;
    logic [2:0]       oc2_cnt;
    logic             pg_rel;
    logic [7:0]       pg_cnt;
    logic [2:0]       trip_cnt;
    logic             pg_oe;
    logic             sync_prev;
    logic             follower;
    logic [2:0]       listen;
    logic [2:0]       miss;
    logic             sync_o;
    logic             sync_oe;
  } sup_s;

  sup_s s_q;
  sup_s s_d;

  // ---------------------------------------------------------------------
  // Input synchronisation and switching clock
  // ---------------------------------------------------------------------
  localparam int NIN = 25;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn;
  logic           tick;
  logic           local_clk;
  logic [8:0]     phase;
  logic [8:0]     cur_period;
  logic           align;

  assign raw_in = {vout_ratio_in, chip_enable_in, bias_1v_ok_in,
                   boost_sense_in, boost_low_in, aux_supply_sense,
                   freq_set_pin, pulse_skip_mode, fb_uv_in, fb_ov1_in,
                   fb_ov2_in, fb_at_ref_in, pwm_comp_in, primary_peak_limit,
                   secondary_peak_limit, temp_hot_in, temp_cool_in,
                   sync_clock_i};

  input_sync #(.WIDTH(NIN)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (raw_in),
    .q        (syn)
  );

  logic [7:0] s_ratio;
  logic s_en, s_b1v, s_bdet, s_blow, s_alow, s_fres, s_pskip;
  logic s_uv, s_ov1, s_ov2, s_ref, s_comp, s_pk1, s_pk2, s_hot, s_cool;
  logic s_sync;

  assign {s_ratio, s_en, s_b1v, s_bdet, s_blow, s_alow, s_fres, s_pskip,
          s_uv, s_ov1, s_ov2, s_ref, s_comp, s_pk1, s_pk2, s_hot, s_cool,
          s_sync} = syn;

  switch_clock_gen #(.PW(PER_W)) u_clk (
    .core_clk  (core_clk),
    .rst       (rst),
    .period    (cur_period),
    .align     (align),
    .tick      (tick),
    .phase     (phase),
    .local_clk (local_clk)
  );

  // ---------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------
  function automatic logic [8:0] clamp_period(input logic [8:0] p);
    if (p < PER_MIN) begin
      return PER_MIN;
    end else if (p > PER_MAX) begin
      return PER_MAX;
    end
    return p;
  endfunction

  // Stretches the period as output voltage falls, capped at the floor.
  function automatic logic [8:0] fold_period(input logic [8:0] base,
                                             input logic [7:0] ratio);
    logic [16:0] p;
    if (ratio == 8'h00) begin
      return PER_FOLD;
    end
    p = (17'(base) * 17'(FOLD_FULL)) / 17'(ratio);
    if (p > 17'(PER_FOLD)) begin
      return PER_FOLD;
    end
    return p[8:0];
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  logic [8:0]  base_period;
  logic        edge_ext;
  logic        pwm_run;
  logic        ov_trip;
  logic        win_ok;
  logic        ramp_ok;
  logic [23:0] ramp_prod;
  logic [23:0] ramp_lim;
  logic [31:0] status;

  assign base_period = s_fres ? clamp_period(s_q.period) : PER_DEF;
  assign cur_period  = s_q.fold ? fold_period(base_period, s_ratio)
                                : base_period;
  assign edge_ext = s_sync & ~s_q.sync_prev & ~s_q.sync_oe & ~s_pskip;
  assign align    = s_q.follower & edge_ext;

  always_comb begin
    s_d       = s_q;
    ramp_prod = 24'((cur_period >> 1) * 24'(s_q.bss_cnt));
    ramp_lim  = ramp_prod / 24'(BOOST_SS_CYC) + 24'h1;
    ramp_ok   = (s_q.bss_cnt >= CNT_W'(BOOST_SS_CYC)) |
                (24'(phase) < ramp_lim);
    win_ok    = ~s_uv & ~s_ov1;
    ov_trip   = s_ov2 | (s_ov1 & (s_q.st != ST_SOFT));
    status    = '0;
    status[ST_PG]     = s_q.pg_rel;
    status[ST_BOOSTM] = s_q.boost_mode;
    status[ST_BOOSTA] = s_q.boost_on;
    status[ST_OVL]    = s_q.ov_lat;
    status[ST_OTL]    = s_q.otp_lat;
    status[ST_FOLLOW] = s_q.follower;
    status[ST_FOLD]   = s_q.fold;
    status[ST_LSB +: 4] = s_q.st;

    // Register bus: address and data are taken in either order.
    if (awvalid & s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = awaddr;
    end
    if (wvalid & s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = wdata;
      s_d.wstrb  = wstrb;
    end
    if (s_q.bvalid & bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have & s_q.w_have & ~s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      if (hit(s_q.awaddr, REG_PERIOD)) begin
        if (s_q.wstrb[0]) begin
          s_d.period[7:0] = s_q.wdata[7:0];
        end
        if (s_q.wstrb[1]) begin
          s_d.period[8] = s_q.wdata[8];
        end
      end else if (!hit(s_q.awaddr, REG_STATUS)) begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    if (s_q.rvalid & rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid & s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      if (hit(araddr, REG_PERIOD)) begin
        s_d.rdata = {23'h0, s_q.period};
      end else if (hit(araddr, REG_STATUS)) begin
        s_d.rdata = status;
      end else begin
        s_d.rdata = '0;
        s_d.rresp = RESP_SLVERR;
      end
    end
    s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
    s_d.wready  = ~s_d.w_have & ~s_d.bvalid;
    s_d.arready = ~s_d.rvalid;

    // Fault latches; a new trip wins over its own release.
    if (ov_trip) begin
      s_d.ov_lat = 1'b1;
    end else if (s_ref) begin
      s_d.ov_lat = 1'b0;
    end
    if (s_hot) begin
      s_d.otp_lat = 1'b1;
    end else if (s_cool) begin
      s_d.otp_lat = 1'b0;
    end
    if (tick) begin
      s_d.fold     = s_q.pk1_seen | s_pk1;
      s_d.pk1_seen = s_pk1;
    end else if (s_pk1) begin
      s_d.pk1_seen = 1'b1;
    end

    // Sequencer.
    case (s_q.st)
      ST_OFF: begin
        if (s_en & ~s_q.otp_lat) begin
          s_d.boost_mode = s_bdet;
          s_d.tcnt       = '0;
          s_d.st         = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (tick) begin
          s_d.tcnt = s_q.tcnt + CNT_W'(1);
          if (s_q.tcnt == CNT_W'(SS_TICKS - 1)) begin
            s_d.st = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        s_d.tcnt = '0;
      end
      ST_HICCUP: begin
        if (tick) begin
          s_d.tcnt = s_q.tcnt + CNT_W'(1);
          if (s_q.tcnt == CNT_W'(HICCUP_MULT * SS_TICKS - 1)) begin
            s_d.tcnt = '0;
            s_d.st   = ST_SOFT;
          end
        end
      end
      default: begin
        s_d.st = ST_OFF;
      end
    endcase

    // Secondary limit: count two periods, then hiccup.
    if ((s_q.st == ST_OFF) | (s_q.st == ST_HICCUP)) begin
      s_d.oc2_pend = 1'b0;
      s_d.oc2_cnt  = '0;
    end else if (s_pk2 & ~s_q.oc2_pend) begin
      s_d.oc2_pend = 1'b1;
      s_d.oc2_cnt  = '0;
    end else if (s_q.oc2_pend & tick) begin
      s_d.oc2_cnt = s_q.oc2_cnt + 3'h1;
    end
    if (s_q.oc2_pend & (s_q.oc2_cnt == OC2_DLY_TICKS)) begin
      s_d.st       = ST_HICCUP;
      s_d.tcnt     = '0;
      s_d.oc2_pend = 1'b0;
    end
    if (~s_en | s_q.otp_lat) begin
      s_d.st = ST_OFF;
    end

    // Gate drive.
    pwm_run = ((s_q.st == ST_SOFT) | (s_q.st == ST_RUN)) & (s_d.st == s_q.st)
              & ~s_q.ov_lat & ~ov_trip & ~s_q.otp_lat & ~s_hot;
    if (!pwm_run) begin
      s_d.hs = 1'b0;
    end else if (tick) begin
      s_d.hs = 1'b1;
    end else if (s_comp | s_pk1) begin
      s_d.hs = 1'b0;
    end
    s_d.boost_on = s_q.boost_mode & (s_blow | s_alow) & pwm_run;
    if (s_d.boost_on & ~s_q.boost_on) begin
      s_d.bss_cnt = '0;
    end else if (s_q.bss_cnt < CNT_W'(BOOST_SS_CYC)) begin
      s_d.bss_cnt = s_q.bss_cnt + CNT_W'(1);
    end
    if (s_q.boost_mode) begin
      s_d.ls = s_d.hs & s_d.boost_on & ramp_ok;
    end else begin
      s_d.ls = ~s_d.hs & pwm_run;
    end

    // Power good.
    if (~s_en | (s_q.st != ST_RUN)) begin
      s_d.pg_rel   = 1'b0;
      s_d.pg_cnt   = '0;
      s_d.trip_cnt = '0;
    end else if (!s_q.pg_rel) begin
      if (!win_ok) begin
        s_d.pg_cnt = '0;
      end else if (tick) begin
        s_d.pg_cnt = s_q.pg_cnt + 8'h1;
        if (s_q.pg_cnt == PG_DLY_TICKS - 8'h1) begin
          s_d.pg_rel = 1'b1;
          s_d.pg_cnt = '0;
        end
      end
    end else if (win_ok) begin
      s_d.trip_cnt = '0;
    end else if (tick) begin
      s_d.trip_cnt = s_q.trip_cnt + 3'h1;
      if (s_q.trip_cnt == PG_TRIP_TICKS - 3'h1) begin
        s_d.pg_rel   = 1'b0;
        s_d.trip_cnt = '0;
      end
    end
    s_d.pg_oe = s_b1v & ~s_d.pg_rel;

    // Sync pin: listen first, then lead or follow.
    s_d.sync_prev = s_sync;
    if (tick & (s_q.listen != LISTEN_TICKS)) begin
      s_d.listen = s_q.listen + 3'h1;
    end
    if (edge_ext) begin
      s_d.follower = 1'b1;
      s_d.miss     = '0;
    end else if (tick & s_q.follower) begin
      s_d.miss = s_q.miss + 3'h1;
      if (s_q.miss == LOSS_TICKS) begin
        s_d.follower = 1'b0;
      end
    end
    s_d.sync_oe = (s_q.listen == LISTEN_TICKS) & ~s_d.follower
                  & ~s_pskip;
    s_d.sync_o  = local_clk & s_d.sync_oe;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q        <= '0;
      s_q.st     <= ST_OFF;
      s_q.period <= PER_DEF;
      s_q.pg_oe  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready        = s_q.awready;
  assign wready         = s_q.wready;
  assign bvalid         = s_q.bvalid;
  assign bresp          = s_q.bresp;
  assign arready        = s_q.arready;
  assign rvalid         = s_q.rvalid;
  assign rdata          = s_q.rdata;
  assign rresp          = s_q.rresp;
  assign sync_clock_o   = s_q.sync_o;
  assign sync_clock_oe  = s_q.sync_oe;
  assign high_side_gate = s_q.hs;
  assign low_side_gate  = s_q.ls;
  assign power_good_out = s_q.pg_rel;
  assign power_good_oe  = s_q.pg_oe;

endmodule

// ### sim/sup_props.sv
// Pin checker for the supervisor; bound to the top module.
// Assumes sim values SS_TICKS 4 and periods of 10 cycles or more.
`timescale 1ns/100ps
module sup_props (
  input wire logic core_clk, rst, chip_enable_in, bias_1v_ok_in,
  input wire logic fb_uv_in, fb_ov1_in, fb_ov2_in, temp_hot_in,
  input wire logic pulse_skip_mode, secondary_peak_limit,
  input wire logic high_side_gate, low_side_gate, power_good_out,
  input wire logic power_good_oe, sync_clock_oe
);
  logic [15:0] ok_q, bad_q, off_q, oc2_q;
  logic        ran_q, stop_q;
  // A stop counts once the high side has run and then both gates stayed off 8 cycles.
  // Cycles in window, and cycles of a trip seen while good is released.
  always_ff @(posedge core_clk or posedge rst)
    if (rst) begin
      ok_q <= '0;
      bad_q <= '0;
      off_q <= '0;
      oc2_q <= '0;
      ran_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      off_q <= (!high_side_gate && !low_side_gate) ?
               off_q + 16'(off_q != 16'hFFFF) : '0;
      oc2_q <= secondary_peak_limit ? oc2_q + 16'(oc2_q != 16'hFFFF) : '0;
      ran_q <= secondary_peak_limit && (ran_q || high_side_gate);
      stop_q <= secondary_peak_limit &&
                (stop_q || (ran_q && off_q >= 16'h0008));
      ok_q <= (chip_enable_in && !fb_uv_in && !fb_ov1_in) ?
              ok_q + 16'(ok_q != 16'hFFFF) : '0;
      bad_q <= (power_good_out && (fb_uv_in || fb_ov1_in)) ?
               bad_q + 16'h0001 : '0;
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence oc2_held;
    secondary_peak_limit[*4];
  endsequence
  AST_OV_GATES: assert property (
    fb_ov2_in[*4] |-> !high_side_gate && !low_side_gate)
    else $error("gates on during overvoltage");
  AST_OT_GATES: assert property (
    temp_hot_in[*4] |-> !high_side_gate && !low_side_gate)
    else $error("gates on while hot");
  AST_EN_PG: assert property (
    (!chip_enable_in)[*4] |-> !power_good_out)
    else $error("power good while disabled");
  AST_BIAS_OE: assert property (
    (!bias_1v_ok_in)[*4] |-> !power_good_oe)
    else $error("pin pulled with bias low");
  AST_SKIP_SYNC: assert property (
    pulse_skip_mode[*4] |-> !sync_clock_oe)
    else $error("sync driven in pulse skip");
  AST_PG_DELAY: assert property (
    $rose(power_good_out) |-> ok_q >= 16'h04F6)
    else $error("power good released early");
  AST_PG_TRIP: assert property (
    bad_q < 16'h03F2)
    else $error("power good held during trip");
  AST_OC2_STOP: assert property (
    oc2_held ##0 (oc2_q == 16'h03F2) |-> stop_q)
    else $error("no stop after second limit");
endmodule
bind regulator_fault_supervisor sup_props chk_u (.*);

// ### sim/stage_model.sv
// Power stage stand-in: ends on-times and offers an external sync clock.
// Assumes the sync line has a pull-down when nobody drives it.
`timescale 1ns/100ps
module stage_model #(
  parameter int ON_CYC  = 6,
  parameter int EXT_PER = 34
) (
  input wire logic core_clk, high_side_gate, overload, ext_on,
  input wire logic sync_clock_o, sync_clock_oe,
  output logic pwm_comp_in, primary_peak_limit, sync_clock_i
);
  int on_q = 0;
  int ext_q = 0;
  always @(posedge core_clk) begin
    on_q <= high_side_gate ? on_q + 1 : 0;
    ext_q <= (ext_q + 1) % EXT_PER;
  end
  // Overload reaches the peak limit before the on-time would end.
  assign pwm_comp_in = (on_q >= ON_CYC) && !overload;
  assign primary_peak_limit = (on_q >= 2) && overload;
  // External clock runs 18 percent above the 40-cycle default.
  assign sync_clock_i = sync_clock_oe ? sync_clock_o :
                        (ext_on && ext_q < EXT_PER / 2);
endmodule

// ### sim/tb_regulator_fault_supervisor.sv
// Bench of the supervisor; reads carry queued expected notes.
// Assumes the stage model on the gate and sync pins.
`timescale 1ns/100ps
module tb_regulator_fault_supervisor;
  import sup_pkg::*;
  typedef struct packed {logic [31:0] d, m; logic [1:0] r;} exp_s;
  logic core_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, chip_enable_in = 0, bias_1v_ok_in = 1;
  logic fb_uv_in = 0, fb_ov1_in = 0, fb_ov2_in = 0, fb_at_ref_in = 1;
  logic temp_hot_in = 0, temp_cool_in = 1, pulse_skip_mode = 0;
  logic secondary_peak_limit = 0, overload = 0, ext_on = 0;
  logic boost_sense_in = 0, boost_low_in = 0, freq_set_pin = 1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, p;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, pwm_comp_in;
  logic primary_peak_limit, sync_clock_i, sync_clock_o, sync_clock_oe;
  logic high_side_gate, low_side_gate, power_good_out, power_good_oe;
  int fail_count = 0, cmp_count = 0;
  exp_s q[$], e;
  always #25 core_clk = ~core_clk;
  regulator_fault_supervisor #(.SS_TICKS(4), .BOOST_SS_CYC(40)) dut_u (
    .wstrb(4'hF), .aux_supply_sense(1'b0),
    .vout_ratio_in(8'hFF), .*);
  stage_model pm_u (.*);
  task automatic rd(input logic [7:0] a, input logic [31:0] d, m,
                    input logic [1:0] r);
    @(posedge core_clk);
    q.push_back('{d, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp_count++;
    if (bresp !== RESP_OKAY) begin
      fail_count++;
      $display("mismatch at %0t: write response", $time);
    end
  endtask
  task automatic wt(input logic v, input int n);
    while (power_good_out !== v && n-- > 0) @(posedge core_clk);
    if (power_good_out !== v) begin
      fail_count++;
      $display("mismatch at %0t: power good wait", $time);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk)
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = q.pop_front();
      cmp_count++;
      if ((rdata & e.m) !== (e.d & e.m) || rresp !== e.r) begin
        fail_count++;
        $display("mismatch at %0t: read %h", $time, rdata);
      end
    end
  initial begin
    #4000000;
    fail_count++;
    results();
  end
  initial begin
    void'($urandom(64));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    ext_on <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(REG_PERIOD, 32'h28, 32'h1FF, RESP_OKAY);
    rd(8'h08, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    repeat (300) @(posedge core_clk);
    rd(REG_STATUS, 32'h20, 32'h20, RESP_OKAY);
    ext_on <= 1'b0;
    p = 32'(10 + $urandom % 91);
    wr(REG_PERIOD, p);
    rd(REG_PERIOD, p, 32'h1FF, RESP_OKAY);
    {boost_sense_in, boost_low_in} <= {2{1'($urandom)}};
    chip_enable_in <= 1'b1;
    wt(1'b1, 20000);
    rd(REG_STATUS, {29'h0, {2{boost_sense_in}}, 1'b1}, 32'h7,
       RESP_OKAY);
    repeat (40) begin
      @(posedge core_clk);
      cmp_count++;
      if (low_side_gate !== (high_side_gate ^ !boost_sense_in)) begin
        fail_count++;
        $display("mismatch at %0t: low-side gate phase", $time);
      end
    end
    fb_uv_in <= 1'b1;
    wt(1'b0, 6 * p + 5);
    fb_uv_in <= 1'b0;
    wt(1'b1, 20000);
    {fb_ov2_in, fb_ov1_in, fb_at_ref_in} <= 3'h6;
    repeat (4) @(posedge core_clk);
    rd(REG_STATUS, 32'h8, 32'h8, RESP_OKAY);
    {fb_ov2_in, fb_ov1_in, fb_at_ref_in} <= 3'h1;
    {temp_hot_in, temp_cool_in, pulse_skip_mode} <= 3'h5;
    repeat (4) @(posedge core_clk);
    rd(REG_STATUS, 32'h110, 32'hF11, RESP_OKAY);
    {temp_hot_in, temp_cool_in, pulse_skip_mode} <= 3'h2;
    {overload, secondary_peak_limit} <= 2'h3;
    repeat (3 * p + 10) @(posedge core_clk);
    rd(REG_STATUS, 32'h800, 32'hF00, RESP_OKAY);
    repeat (1000) @(posedge core_clk);
    {overload, secondary_peak_limit, chip_enable_in} <= 3'h0;
    repeat (4) @(posedge core_clk);
    rd(REG_STATUS, 32'h100, 32'hF01, RESP_OKAY);
    bias_1v_ok_in <= 1'b0;
    repeat (6) @(posedge core_clk);
    cmp_count++;
    if (power_good_oe !== 1'b0) begin
      fail_count++;
      $display("mismatch at %0t: power good pin pulled", $time);
    end
    results();
  end
endmodule
